// File: hdl/vrt_timing.sv
`timescale 1ns/1ps
// Functional notes
// R1 - Prescaler reloads 7 on carry, divides nine
// R2 - Interval counter divides carries by thirteen
// R3 - Hsync matches carry width, one interval later
// R4 - Hsync triggers adjustable one-shot horizontal blanking
// R5 - Dot clock runs only outside horizontal blanking
// R6 - Sweep counter advances once per sweep carry
// R7 - Sweep reset low one interval, every 15th
// R8 - Line counter advances every fifteen sweeps
// R9 - Line MSB marks bottom half of text
// R10 - Vertical blanking covers sweep 240 onward, 37 bottom sweeps
// R11 - Test mode: seven blanked, thirty unblanked sweeps
// R12 - Test decoder: 7 off, 8 on, 7 off, 15 on
// R13 - Symbol counter counts strobes, optional 64 wide
// R14 - Horizontal blanking holds symbol counter at zero
// R15 - Symbol and line counts address display RAM
// R16 - Dot blank pulse once per sweep, settable
// R17 - Dot counter reloads 6, strobe every tenth
// R18 - Strobe latches character and advances address
// R19 - Vertical sync recurs every 277 sweeps
// R20 - Sixteen text lines make 240 visible sweeps
// R21 - Everything synchronous, carries used as enables
module vrt_timing import vrt_pkg::*; (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Settings and test pins.
  input wire logic [7:0] pos_set,
  input wire logic [3:0] width_set,
  input wire logic wide_line,
  input wire logic vtest_n,
  // Display memory.
  input wire logic [7:0] ram_rdata,
  input wire logic cpu_access,
  input wire logic [9:0] cpu_addr,
  output logic [9:0] ram_addr,
  output logic [1:0] ram_cs,
  output logic [7:0] char_latch,
  // Monitor and dot path.
  output logic comp_sync,
  output logic video_blank,
  output logic dot_blank,
  output logic dot_en,
  output logic eoc,
  output logic line_msb,
  output logic vdec_out
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic [8:0] wrap_inc(input logic [8:0] cnt,
      input logic [8:0] last);
    wrap_inc = (cnt == last) ? 9'h000 : cnt + 9'h001;
  endfunction

  function automatic logic [1:0] bank_dec(input logic [9:0] addr);
    bank_dec = addr[9] ? 2'b10 : 2'b01;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the pots and test clip are asynchronous.

  logic [13:0] pin_s1_reg;
  logic [13:0] pin_s2_reg;
  logic [7:0] pos_s;
  logic [3:0] width_s;
  logic wide_s;
  logic vtest_n_s;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_s1_reg <= PIN_SYNC_RST;
      pin_s2_reg <= PIN_SYNC_RST;
    end else begin
      pin_s1_reg <= {vtest_n, wide_line, width_set, pos_set};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign pos_s = pin_s2_reg[7:0];
  assign width_s = pin_s2_reg[11:8];
  assign wide_s = pin_s2_reg[12];
  assign vtest_n_s = pin_s2_reg[13];

  ////////////////////////////////////////////////////////////////////////
  // Horizontal divider chain.

  vrt_h_if hb ();

  vrt_hdiv u_hdiv (
    .core_clk(core_clk),
    .srst(srst),
    .hb(hb.src)
  );

  ////////////////////////////////////////////////////////////////////////
  // Horizontal blanking one-shot, stretched beyond hsync by pos setting.

  logic [8:0] hb_cnt_reg;
  logic hblank;
  logic hblank_d_reg;

  assign hblank = (hb_cnt_reg != 9'h000);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      hb_cnt_reg <= 9'h000;
    end else if (hb.hsync_start) begin
      hb_cnt_reg <= {1'b0, pos_s} + HSYNC_CLKS; // [R4]
    end else if (hblank) begin
      hb_cnt_reg <= hb_cnt_reg - 9'h001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      hblank_d_reg <= 1'b0;
    end else begin
      hblank_d_reg <= hblank;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Dot rate divider; the width setting picks the dot period.

  logic [3:0] div_reg;
  logic dot_tick;

  assign dot_tick = !hblank && (div_reg == width_s); // [R5]

  always_ff @(posedge core_clk) begin
    if (srst) begin
      div_reg <= 4'h0;
    end else if (hblank || dot_tick) begin
      div_reg <= 4'h0; // [R5]
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Dot counter: end of character on every tenth dot.

  logic [3:0] dot_reg;
  logic eoc_tick;

  assign eoc_tick = dot_tick && (dot_reg == DOT_MAX);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      dot_reg <= DOT_RELOAD;
    end else if (dot_tick) begin
      dot_reg <= eoc_tick ? DOT_RELOAD : dot_reg + 4'h1; // [R17] [R21]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Symbol counter; the top stage only runs for 64-symbol lines.

  logic [5:0] sym_reg;

  always_ff @(posedge core_clk) begin
    if (srst || hblank) begin
      sym_reg <= 6'h00; // [R14]
    end else if (eoc_tick) begin
      if (wide_s) begin
        sym_reg <= sym_reg + 6'h01; // [R13]
      end else begin
        sym_reg <= {1'b0, sym_reg[4:0] + 5'h01}; // [R13]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Dot blank: from end of blanking to the first character strobe.

  logic dblank_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      dblank_reg <= 1'b0;
    end else if (hblank_d_reg && !hblank) begin
      dblank_reg <= 1'b1; // [R16]
    end else if (eoc_tick || hblank) begin
      dblank_reg <= 1'b0; // [R16]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame sweep count; restarting sweep and line counts at the frame
  // boundary keeps text rows aligned, since 277 is not a multiple of 15.

  logic [8:0] frame_reg;
  logic frame_wrap;

  assign frame_wrap = hb.sweep_edge && (frame_reg == FRAME_LAST);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      frame_reg <= 9'h000;
    end else if (hb.sweep_edge) begin
      frame_reg <= wrap_inc(frame_reg, FRAME_LAST); // [R19]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sweep counter with its delayed low-active reset pulse.

  logic [3:0] sw_reg;
  logic swrst_n_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      swrst_n_reg <= 1'b1;
    end else if (hb.hsync_start && sw_reg == SWEEP_TERM) begin
      swrst_n_reg <= 1'b0; // [R7]
    end else if (hb.base_tick) begin
      swrst_n_reg <= 1'b1; // [R7]
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || frame_wrap || !swrst_n_reg) begin
      sw_reg <= 4'h0; // [R7]
    end else if (hb.sweep_edge) begin
      sw_reg <= sw_reg + 4'h1; // [R6] [R21]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line counter: one step per text row of fifteen sweeps.

  logic [3:0] line_reg;

  always_ff @(posedge core_clk) begin
    if (srst || frame_wrap) begin
      line_reg <= 4'h0;
    end else if (hb.hsync_start && sw_reg == SWEEP_TERM) begin
      line_reg <= line_reg + 4'h1; // [R8]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Vertical decode, normal and forced-test sequences.

  logic [8:0] test_reg;
  logic test_mode;
  logic vblank;
  logic vsync;
  logic vdec;

  assign test_mode = !vtest_n_s;

  always_ff @(posedge core_clk) begin
    if (srst || !test_mode) begin
      test_reg <= 9'h000;
    end else if (hb.sweep_edge) begin
      test_reg <= wrap_inc(test_reg, TEST_LAST); // [R11]
    end
  end

  always_comb begin
    if (test_mode) begin
      vblank = (test_reg < TEST_BLANK); // [R11]
      vdec = (test_reg >= TEST_DEC_ON1 && test_reg < TEST_DEC_OFF) ||
        (test_reg >= TEST_DEC_ON2); // [R12]
      vsync = 1'b0;
    end else begin
      vblank = (frame_reg >= VISIBLE_SWEEPS); // [R10] [R20]
      vdec = (frame_reg >= VISIBLE_SWEEPS) &&
        (frame_reg < VISIBLE_SWEEPS + VBLANK_BOTTOM);
      vsync = (frame_reg == VSYNC_SWEEP); // [R19]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  logic [9:0] addr_next;

  assign addr_next = cpu_access ? cpu_addr : {line_reg, sym_reg}; // [R15]

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ram_addr <= 10'h000;
      ram_cs <= 2'h1;
    end else begin
      ram_addr <= addr_next; // [R15] [R18]
      ram_cs <= bank_dec(addr_next); // [R15]
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      char_latch <= 8'h00;
    end else if (eoc_tick) begin
      char_latch <= ram_rdata; // [R18]
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      comp_sync <= 1'b0;
      video_blank <= 1'b1;
      dot_blank <= 1'b0;
      dot_en <= 1'b0;
      eoc <= 1'b0;
      line_msb <= 1'b0;
      vdec_out <= 1'b0;
    end else begin
      comp_sync <= hb.hsync | vsync; // [R3]
      video_blank <= hblank | vblank; // [R4] [R10]
      dot_blank <= dblank_reg;
      dot_en <= dot_tick;
      eoc <= eoc_tick;
      line_msb <= line_reg[3]; // [R9]
      vdec_out <= vdec;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  property p_blank_start;
    hb.hsync_start |=> hblank [*8] ##1 hblank;
  endproperty
  a_blank_start: assert property (p_blank_start) else $error("blank short"); // [R4]

  property p_no_dots;
    hblank |-> !dot_tick ##1 !dot_en;
  endproperty
  a_no_dots: assert property (p_no_dots) else $error("dot in blanking"); // [R5]

  property p_dot_reload;
    eoc_tick |=> dot_reg == DOT_RELOAD && eoc;
  endproperty
  a_dot_reload: assert property (p_dot_reload) else $error("dot reload wrong"); // [R17]

  property p_sym_clear;
    hblank |=> sym_reg == 6'h00;
  endproperty
  a_sym_clear: assert property (p_sym_clear) else $error("symbol not held"); // [R14]

  property p_swrst_width;
    $fell(swrst_n_reg) |-> !swrst_n_reg [*8] ##1 !swrst_n_reg ##1 swrst_n_reg;
  endproperty
  a_swrst_width: assert property (p_swrst_width) else $error("sweep reset width"); // [R7]

  property p_line_step;
    $fell(swrst_n_reg) |-> line_reg == $past(line_reg) + 4'h1;
  endproperty
  a_line_step: assert property (p_line_step) else $error("line not stepped"); // [R8]

  property p_frame_wrap;
    frame_wrap |=> frame_reg == 9'h000 && sw_reg == 4'h0 && line_reg == 4'h0;
  endproperty
  a_frame_wrap: assert property (p_frame_wrap) else $error("frame wrap wrong"); // [R19]

  property p_latch;
    eoc_tick |=> char_latch == $past(ram_rdata);
  endproperty
  a_latch: assert property (p_latch) else $error("char not latched"); // [R18]

  property p_test_range;
    test_reg <= TEST_LAST;
  endproperty
  a_test_range: assert property (p_test_range) else $error("test count range"); // [R12]

  property p_vblank_bottom;
    !test_mode && frame_reg == VISIBLE_SWEEPS |-> vblank ##1 video_blank;
  endproperty
  a_vblank_bottom: assert property (p_vblank_bottom) else $error("no vblank"); // [R10]

endmodule

// File: hdl/vrt_pkg.sv
package vrt_pkg;
  // Horizontal chain.
  localparam logic [3:0] HPRE_RELOAD = 4'h7;
  localparam logic [3:0] HPRE_MAX = 4'hf;
  localparam logic [3:0] HINT_LAST = 4'hc;
  localparam logic [3:0] HINT_FIRST = 4'h0;
  localparam logic [8:0] HSYNC_CLKS = 9'h009;
  // Dot and symbol chain.
  localparam logic [3:0] DOT_RELOAD = 4'h6;
  localparam logic [3:0] DOT_MAX = 4'hf;
  // Sweep and line chain.
  localparam logic [3:0] SWEEP_TERM = 4'hf;
  localparam logic [8:0] FRAME_LAST = 9'h114;
  localparam logic [8:0] VISIBLE_SWEEPS = 9'h0f0;
  localparam logic [8:0] VBLANK_BOTTOM = 9'h008;
  localparam logic [8:0] VSYNC_SWEEP = 9'h0f8;
  // Forced vertical test sequence.
  localparam logic [8:0] TEST_LAST = 9'h024;
  localparam logic [8:0] TEST_BLANK = 9'h007;
  localparam logic [8:0] TEST_DEC_ON1 = 9'h007;
  localparam logic [8:0] TEST_DEC_OFF = 9'h00f;
  localparam logic [8:0] TEST_DEC_ON2 = 9'h016;
  // Pin synchroniser reset: test pin idles high.
  localparam logic [13:0] PIN_SYNC_RST = 14'h2000;
endpackage

// File: hdl/vrt_h_if.sv
`timescale 1ns/1ps
interface vrt_h_if;
  logic base_tick;
  logic sweep_carry;
  logic sweep_edge;
  logic hsync;
  logic hsync_start;
  modport src (output base_tick, output sweep_carry, output sweep_edge,
    output hsync, output hsync_start);
  modport dst (input base_tick, input sweep_carry, input sweep_edge,
    input hsync, input hsync_start);
endinterface

// File: hdl/vrt_hdiv.sv
`timescale 1ns/1ps
module vrt_hdiv import vrt_pkg::*; (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Horizontal timing out.
  vrt_h_if.src hb
);

  logic [3:0] pre_reg;
  logic [3:0] pre_next;
  logic [3:0] int_reg;
  logic [3:0] int_next;

  assign hb.base_tick = (pre_reg == HPRE_MAX);
  assign hb.sweep_carry = (int_reg == HINT_LAST);
  assign hb.hsync = (int_reg == HINT_FIRST);
  assign hb.sweep_edge = hb.base_tick && (int_reg == HINT_LAST - 4'h1);
  assign hb.hsync_start = hb.base_tick && hb.sweep_carry;

  always_comb begin
    pre_next = hb.base_tick ? HPRE_RELOAD : pre_reg + 4'h1; // [R1]
    int_next = int_reg;
    if (hb.base_tick) begin
      int_next = hb.sweep_carry ? HINT_FIRST : int_reg + 4'h1; // [R2]
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pre_reg <= HPRE_RELOAD;
      int_reg <= HINT_FIRST;
    end else begin
      pre_reg <= pre_next;
      int_reg <= int_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  property p_pre_div9;
    hb.base_tick |=> !hb.base_tick [*8] ##1 hb.base_tick;
  endproperty
  a_pre_div9: assert property (p_pre_div9) else $error("prescale not /9"); // [R1]

  property p_sweep_117;
    hb.sweep_edge |-> ##117 hb.sweep_edge;
  endproperty
  a_sweep_117: assert property (p_sweep_117) else $error("sweep not 13 intervals"); // [R2]

  property p_hsync_late;
    $rose(hb.sweep_carry) |-> ##9 $rose(hb.hsync);
  endproperty
  a_hsync_late: assert property (p_hsync_late) else $error("hsync not one interval late"); // [R3]

  property p_hsync_width;
    $rose(hb.hsync) |-> hb.hsync [*8] ##1 hb.hsync ##1 !hb.hsync;
  endproperty
  a_hsync_width: assert property (p_hsync_width) else $error("hsync width wrong"); // [R3]

endmodule

// File: test/vrt_crt_mon.sv
`timescale 1ns/1ps
// Monitor-side sync separator that times every composite sync pulse.
module vrt_crt_mon (
  // Clock.
  input wire logic core_clk,
  // Composite sync from the board.
  input wire logic comp_sync,
  // Measurements in clocks and pulse counts.
  output int h_period,
  output int h_width,
  output int h_count,
  output int v_period,
  output int v_count
);
  int now_c = 0;
  int rise_c = 0;
  int last_h = 0;
  int last_v = 0;
  logic prev = 1'b0;

  // Like a real set, a pulse wider than a few intervals is taken as vertical sync.
  // The first horizontal period after a vertical pulse is stale and is not used.
  always @(posedge core_clk) begin
    now_c <= now_c + 1;
    prev <= comp_sync;
    if (comp_sync === 1'b1 && prev === 1'b0) begin
      rise_c <= now_c;
    end
    if (comp_sync === 1'b0 && prev === 1'b1) begin
      if (now_c - rise_c > 50) begin
        v_period <= rise_c - last_v;
        last_v <= rise_c;
        v_count <= v_count + 1;
      end else begin
        h_period <= rise_c - last_h;
        last_h <= rise_c;
        h_width <= now_c - rise_c;
        h_count <= h_count + 1;
      end
    end
  end
endmodule

// File: test/video_raster_timing_chain_test.sv
`timescale 1ns/1ps
module video_raster_timing_chain_test;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] pos_set = 8'h00;
  logic [3:0] width_set = 4'h0;
  logic wide_line = 1'b0;
  logic vtest_n = 1'b1;
  logic [7:0] ram_rdata = 8'h00;
  logic cpu_access = 1'b0;
  logic [9:0] cpu_addr = 10'h000;
  logic [9:0] ram_addr;
  logic [1:0] ram_cs;
  logic [7:0] char_latch;
  logic comp_sync, video_blank, dot_blank, dot_en, eoc, line_msb, vdec_out;
  int h_period, h_width, h_count, v_period, v_count;
  int bad_count = 0;
  int comparisons = 0;
  int n, m, h1, h2;
  logic [31:0] exp_q[$];
  logic [31:0] res_q[$];

  always #5 core_clk = ~core_clk;

  vrt_timing dut (.core_clk, .srst, .pos_set, .width_set, .wide_line, .vtest_n,
    .ram_rdata, .cpu_access, .cpu_addr, .ram_addr, .ram_cs, .char_latch, .comp_sync,
    .video_blank, .dot_blank, .dot_en, .eoc, .line_msb, .vdec_out);

  vrt_crt_mon crt (.core_clk, .comp_sync, .h_period, .h_width, .h_count, .v_period,
    .v_count);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic sig(input int s);
    case (s)
      0: return video_blank;
      1: return eoc;
      2: return dot_blank;
      3: return line_msb;
      4: return vdec_out;
      default: return ram_addr[6];
    endcase
  endfunction

  // Rounds a clock count to whole sweeps, so a few clocks of register lag or a
  // trailing horizontal blank cannot move the result.
  function automatic int sw(input int c);
    return (c + 58) / 117;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      bad_count++;
      $display("BAD t=%0t got=%h want=%h", $time, got, want);
    end
  endtask

  task automatic end_sim();
    wait (res_q.size() == 0 || exp_q.size() == 0);
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic note(input logic [31:0] want, input logic [31:0] got);
    exp_q.push_back(want);
    res_q.push_back(got);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask

  // Counts cycles while a signal holds a level; a stuck signal ends the run.
  task automatic run(input int s, input logic v, output int len);
    len = 0;
    while (sig(s) === v) begin
      @(negedge core_clk);
      len++;
      if (len > 40000) begin
        bad_count++;
        end_sim();
      end
    end
  endtask

  initial begin
    forever begin
      wait (res_q.size() > 0 && exp_q.size() > 0);
      check(res_q.pop_front(), exp_q.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(81110));
    pos_set = 8'($urandom_range(31));
    width_set = 4'($urandom_range(1));
    wide_line = 1'($urandom_range(1));
    cyc(8);
    note(32'h1, video_blank);
    note(32'h1, ram_cs);
    note(32'h0, comp_sync);
    cyc(2);
    srst = 1'b0;
    cyc(600);
    note(117, h_period);
    note(9, h_width);
    run(0, 1'b1, n);
    run(0, 1'b0, n);
    cyc(4);
    note(32'h0, ram_addr[5:0]);
    run(0, 1'b1, n);
    note(9 + pos_set, n + 4);
    run(1, 1'b0, n);
    run(1, 1'b1, n);
    run(1, 1'b0, n);
    note(10 * (width_set + 1) - 1, n);
    repeat (6) begin
      cyc(2);
      ram_rdata = 8'($urandom);
      run(1, 1'b0, n);
      cyc(2);
      note(ram_rdata, char_latch);
    end
    m = 0;
    repeat (300) begin
      cyc(1);
      if (dot_en === 1'b1 && video_blank === 1'b1) begin
        m++;
      end
    end
    note(0, m);
    run(2, 1'b1, n);
    run(2, 1'b0, n);
    run(2, 1'b1, n);
    run(2, 1'b0, m);
    note(117, n + m);
    cpu_access = 1'b1;
    repeat (4) begin
      cpu_addr = 10'($urandom);
      cyc(2);
      note(cpu_addr, ram_addr);
      note(cpu_addr[9] ? 2'b10 : 2'b01, ram_cs);
    end
    cpu_access = 1'b0;
    // The address register takes the display address again at the next edge.
    cyc(2);
    run(5, 1'b1, n);
    run(5, 1'b0, n);
    run(5, 1'b1, n);
    note(15, sw(n));
    run(3, 1'b0, n);
    cyc(3);
    note(1, ram_addr[9]);
    note(2'b10, ram_cs);
    run(3, 1'b1, n);
    note(120, sw(n + 3));
    fork
      begin
        run(4, 1'b0, n);
        run(4, 1'b1, n);
      end
      begin
        run(4, 1'b0, m);
        run(0, 1'b1, m);
      end
    join
    note(8, sw(n));
    note(37, sw(m));
    for (n = 0; v_count < 2 && n < 70000; n++) begin
      cyc(1);
    end
    if (v_count < 2) begin
      bad_count++;
      end_sim();
    end
    note(277 * 117, v_period);
    // The forced sequence is entered through reset so it starts from a known sweep.
    srst = 1'b1;
    vtest_n = 1'b0;
    cyc(10);
    srst = 1'b0;
    run(4, 1'b1, n);
    run(4, 1'b0, n);
    note(7, sw(n));
    run(4, 1'b1, h1);
    run(4, 1'b0, n);
    note(7, sw(n));
    run(4, 1'b1, h2);
    note(23, sw(h1) + sw(h2));
    note(120, sw(h1) * sw(h2));
    for (m = 0; m < 100; m++) begin
      run(0, 1'b0, n);
      run(0, 1'b1, n);
      if (n > 300) begin
        break;
      end
    end
    note(7, sw(n));
    // From the end of vertical blank to the next one, short blanks included.
    h1 = 0;
    for (m = 0; m < 100; m++) begin
      run(0, 1'b0, n);
      h1 += n;
      run(0, 1'b1, n);
      if (n > 300) begin
        break;
      end
      h1 += n;
    end
    note(30, sw(h1));
    end_sim();
  end
endmodule
